// file: logic/dacreg_channel.sv
// one converter channel's transmit gate: source select, alarm mute, idle code
// assumes alarm, mask and sample inputs are on i_ref_clk, pin already synchronised
`timescale 1ns/1ns
module dacreg_channel
   import dacreg_pkg::*;
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_tx_pin,
   input  wire logic                i_source_reg,
   input  wire logic                i_reg_enable,
   input  wire logic                i_mute_enable,
   input  wire logic                i_asleep,
   input  wire logic [ALARM_W-1:0]  i_alarm,
   input  wire logic [ALARM_W-1:0]  i_mute_mask,
   input  wire logic [SAMPLE_W-1:0] i_sample,
   output logic [SAMPLE_W-1:0]      o_sample,
   output logic                     o_active,
   output logic                     o_muted
);

   typedef struct packed {
      logic [SAMPLE_W-1:0] sample;
      logic                active;
      logic                muted;
   } dacreg_chan_reg_t;

   dacreg_chan_reg_t q;
   dacreg_chan_reg_t next_q;

   always_comb begin
      logic enable;
      logic mute;
      enable = i_source_reg ? i_reg_enable : i_tx_pin; // RULE_14 RULE_15 RULE_17
      // unmasked alarms only, and only while auto mute is on
      mute   = i_mute_enable & (|(i_alarm & ~i_mute_mask)); // RULE_12 RULE_13
      next_q        = q;
      next_q.muted  = mute;
      next_q.active = enable & ~mute & ~i_asleep;
      // idle code keeps the output quiet rather than holding a stale sample
      next_q.sample = next_q.active ? i_sample : IDLE_CODE; // RULE_19
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q        <= '0;
         q.sample <= IDLE_CODE;
      end else begin
         q <= next_q;
      end
   end

   assign o_sample = q.sample;
   assign o_active = q.active;
   assign o_muted  = q.muted;

endmodule

// file: logic/dacreg_pkg.sv
// constants, field positions and types for the converter control register bank
// assumes one 125 MHz clock and a serial register port sampled on that clock
package dacreg_pkg;

   localparam int ADDR_W   = 15;
   localparam int DATA_W   = 8;
   localparam int SAMPLE_W = 12;
   localparam int ALARM_W  = 8;

   // register offsets
   localparam logic [14:0] OFS_INTERFACE_CONFIG      = 15'h0000;
   localparam logic [14:0] OFS_DEVICE_POWER_CONFIG   = 15'h0002;
   localparam logic [14:0] OFS_DEVICE_CLASS          = 15'h0003;
   localparam logic [14:0] OFS_PART_IDENT_LO         = 15'h0004;
   localparam logic [14:0] OFS_PART_IDENT_HI         = 15'h0005;
   localparam logic [14:0] OFS_SILICON_REVISION      = 15'h0006;
   localparam logic [14:0] OFS_MAKER_IDENT_LO        = 15'h000c;
   localparam logic [14:0] OFS_MAKER_IDENT_HI        = 15'h000d;
   localparam logic [14:0] OFS_SLEEP_PIN_CONFIG      = 15'h0020;
   localparam logic [14:0] OFS_TRANSMIT_SOURCE_SEL   = 15'h0021;
   localparam logic [14:0] OFS_TRANSMIT_ENABLE_BITS  = 15'h0022;

   // reset values
   localparam logic [7:0] RST_INTERFACE_CONFIG     = 8'h30;
   localparam logic [7:0] RST_DEVICE_POWER_CONFIG  = 8'h00;
   localparam logic [3:0] RST_DEVICE_CLASS_HI      = 4'h0;
   localparam logic [7:0] RST_SLEEP_PIN_CONFIG     = 8'h00;
   localparam logic [7:0] RST_TRANSMIT_SOURCE_SEL  = 8'h0f;
   localparam logic [7:0] RST_TRANSMIT_ENABLE_BITS = 8'h00;
   localparam logic [7:0] UNMAPPED_READ            = 8'h00;

   // field positions
   localparam int BIT_CHIP_RESET        = 7;
   localparam int BIT_STREAM_DIRECTION  = 5;
   localparam int BIT_ALWAYS_ONE        = 4;
   localparam int BIT_SLEEP_PIN_DEEP    = 0;
   localparam int BIT_ALARM_MUTE_EN_B   = 3;
   localparam int BIT_ALARM_MUTE_EN_A   = 2;
   localparam int BIT_TX_SOURCE_SEL_B   = 1;
   localparam int BIT_TX_SOURCE_SEL_A   = 0;
   localparam int BIT_TX_REG_ENABLE_B   = 1;
   localparam int BIT_TX_REG_ENABLE_A   = 0;

   // power modes held in bits 1-0 of the power config register
   typedef enum logic [1:0] {
      PMODE_NORMAL     = 2'b00,
      PMODE_REDUCED    = 2'b01,
      PMODE_SLEEP      = 2'b10,
      PMODE_POWER_DOWN = 2'b11
   } dacreg_pmode_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_CMD  = 2'b01,
      SPI_DATA = 2'b10
   } dacreg_spi_state_t;

   // chip reset interval, a longest time so it rounds down, never below one cycle
   localparam int CLK_PERIOD_NS     = 8;
   localparam int SOFT_RESET_NS     = 5;
   localparam int SOFT_RESET_CYCLES =
      (SOFT_RESET_NS / CLK_PERIOD_NS) < 1 ? 1 : (SOFT_RESET_NS / CLK_PERIOD_NS);

   // output code of a silent channel
   localparam logic [11:0] IDLE_CODE = 12'h800;

endpackage

// file: logic/dacreg_spi_port.sv
// serial register port: 16-bit command (read flag, 15-bit address) then data bytes
// assumes serial clock well below an eighth of i_ref_clk; pins are asynchronous
`timescale 1ns/1ns
module dacreg_spi_port
   import dacreg_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_sclk,
   input  wire logic              i_cs_b,
   input  wire logic              i_sdi,
   input  wire logic              i_stream_up,
   input  wire logic [7:0]        i_rd_data,
   output logic [ADDR_W-1:0]      o_addr,
   output logic                   o_wr,
   output logic [ADDR_W-1:0]      o_wr_addr,
   output logic [7:0]             o_wdata,
   output logic                   o_sdo,
   output logic                   o_sdo_oe_b
);

   typedef struct packed {
      logic              sclk_s1;
      logic              sclk_s2;
      logic              sclk_d;
      logic              cs_b_s1;
      logic              cs_b_s2;
      logic              sdi_s1;
      logic              sdi_s2;
      dacreg_spi_state_t state;
      logic [3:0]        bitcnt;
      logic [15:0]       cmd;
      logic              rnw;
      logic [ADDR_W-1:0] addr;
      logic              load;
      logic [7:0]        shift_out;
      logic              wr;
      logic [ADDR_W-1:0] wr_addr;
      logic [7:0]        wdata;
      logic              sdo;
      logic              sdo_oe_b;
   } dacreg_spi_reg_t;

   dacreg_spi_reg_t q;
   dacreg_spi_reg_t next_q;

   always_comb begin
      logic rise;
      logic fall;
      rise = q.sclk_s2 & ~q.sclk_d;
      fall = ~q.sclk_s2 & q.sclk_d;
      next_q = q;
      next_q.sclk_s1 = i_sclk;
      next_q.sclk_s2 = q.sclk_s1;
      next_q.sclk_d  = q.sclk_s2;
      next_q.cs_b_s1 = i_cs_b;
      next_q.cs_b_s2 = q.cs_b_s1;
      next_q.sdi_s1  = i_sdi;
      next_q.sdi_s2  = q.sdi_s1;
      next_q.wr      = 1'b0;
      next_q.load    = 1'b0;
      if (q.load) begin
         next_q.shift_out = i_rd_data;
      end
      if (q.cs_b_s2) begin
         next_q.state    = SPI_IDLE;
         next_q.bitcnt   = 4'h0;
         next_q.sdo_oe_b = 1'b1;
      end else begin
         case (q.state)
            SPI_IDLE: begin
               next_q.state  = SPI_CMD;
               next_q.bitcnt = 4'h0;
            end
            SPI_CMD: begin
               if (rise) begin
                  next_q.cmd    = {q.cmd[14:0], q.sdi_s2};
                  next_q.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == 4'hf) begin
                     next_q.rnw    = q.cmd[14];
                     next_q.addr   = {q.cmd[13:0], q.sdi_s2};
                     next_q.state  = SPI_DATA;
                     next_q.bitcnt = 4'h0;
                     next_q.load   = 1'b1;
                  end
               end
            end
            SPI_DATA: begin
               if (rise) begin
                  next_q.wdata  = {q.wdata[6:0], q.sdi_s2};
                  next_q.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == 4'h7) begin
                     next_q.bitcnt  = 4'h0;
                     next_q.wr      = ~q.rnw;
                     next_q.wr_addr = q.addr;
                     next_q.load    = 1'b1;
                     next_q.addr    = i_stream_up ? q.addr + 15'h0001
                                                  : q.addr - 15'h0001; // RULE_04
                  end
               end
               if (fall && q.rnw) begin
                  next_q.sdo       = q.shift_out[7];
                  next_q.shift_out = {q.shift_out[6:0], 1'b0};
                  next_q.sdo_oe_b  = 1'b0;
               end
            end
            default: next_q.state = SPI_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q          <= '0;
         q.cs_b_s1  <= 1'b1;
         q.cs_b_s2  <= 1'b1;
         q.sdo_oe_b <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign o_addr     = q.addr;
   assign o_wr       = q.wr;
   assign o_wr_addr  = q.wr_addr;
   assign o_wdata    = q.wdata;
   assign o_sdo      = q.sdo;
   assign o_sdo_oe_b = q.sdo_oe_b;

endmodule

// file: logic/dacreg_top.sv
// control register bank front: chip reset, power mode, identity, transmit enable
// assumes a serial register host on the pins and same-clock alarm and sample logic
`timescale 1ns/1ns
//
// Contract
// (RULE_01) writing one to bit 7 of interface config resets every register
// (RULE_02) the chip reset bit clears itself and always reads zero
// (RULE_03) host waits out the short reset interval before further transactions
// (RULE_04) direction bit set steps stream addresses up, clear steps them down
// (RULE_05) power mode field: 0 normal, 2 sleep, 3 full power-down
// (RULE_06) host never writes power mode value 1
// (RULE_07) sleep powers down both converters, clock, reference, receivers, sensor
// (RULE_08) read-only four-bit class code in bits 3-0, writes ignored
// (RULE_09) read-only sixteen-bit part code, fixed on every read
// (RULE_10) sleep pin acts as mode 2, or mode 3 when its config bit is set
// (RULE_11) sleep pin changes operating state only, stored mode field untouched
// (RULE_12) alarm mute enable set mutes its channel on unmasked alarms
// (RULE_13) alarm mute enable clear means no alarm mutes that channel
// (RULE_14) source select zero gives the transmit pin control, register bit ignored
// (RULE_15) source select one gives the register bit control, pin ignored
// (RULE_16) transmit source select register resets to 0x0f
// (RULE_17) transmit enable bits 1 and 0 enable B and A, reset zero
// (RULE_18) sixteen-bit codes sit low byte first at the lower address
// (RULE_19) a disabled or muted channel drives a fixed idle code
module dacreg_top
   import dacreg_pkg::*;
#(
   parameter logic [3:0]  DEVICE_CLASS_CODE = 4'h9,    // arbitrary value
   parameter logic [15:0] PART_CODE         = 16'h1234, // arbitrary value
   parameter logic [7:0]  REVISION_CODE     = 8'h01,    // arbitrary value
   parameter logic [15:0] MAKER_CODE        = 16'h5a5a  // arbitrary value
)
(
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_spi_sclk,
   input  wire logic                i_spi_cs_b,
   input  wire logic                i_spi_sdi,
   output logic                     o_spi_sdo,
   output logic                     o_spi_sdo_oe_b,
   input  wire logic                i_sleep_pin,
   input  wire logic                i_txenable_pin,
   input  wire logic [ALARM_W-1:0]  i_alarm,
   input  wire logic [ALARM_W-1:0]  i_mute_mask,
   input  wire logic [SAMPLE_W-1:0] i_sample_a,
   input  wire logic [SAMPLE_W-1:0] i_sample_b,
   output logic [SAMPLE_W-1:0]      o_converter_a_sample,
   output logic [SAMPLE_W-1:0]      o_converter_b_sample,
   output logic                     o_converter_a_active,
   output logic                     o_converter_b_active,
   output logic                     o_converter_a_muted,
   output logic                     o_converter_b_muted,
   output logic                     o_chip_reset,
   output logic                     o_converter_a_sleep,
   output logic                     o_converter_b_sleep,
   output logic                     o_clock_rx_sleep,
   output logic                     o_reference_sleep,
   output logic                     o_lvds_rx_sleep,
   output logic                     o_temp_sensor_sleep,
   output logic                     o_power_down,
   output logic [1:0]               o_power_mode
);

   typedef struct packed {
      logic [7:0] interface_config;
      logic [7:0] device_power_config;
      logic [3:0] device_class_hi;
      logic [7:0] sleep_pin_config;
      logic [7:0] transmit_source_select;
      logic [7:0] transmit_enable_bits;
      logic [1:0] reset_cnt;
      logic       chip_reset;
      logic       sleep_s1;
      logic       sleep_s2;
      logic       transmit_enable_bits_s1;
      logic       transmit_enable_bits_s2;
      logic       asleep;
      logic       power_down;
      logic [1:0] power_mode;
   } dacreg_top_reg_t;

   dacreg_top_reg_t q;
   dacreg_top_reg_t next_q;

   logic [ADDR_W-1:0] spi_addr;
   logic              spi_wr;
   logic [ADDR_W-1:0] spi_wr_addr;
   logic [7:0]        spi_wdata;
   logic [7:0]        rd_data;

   function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a,
                                           input dacreg_top_reg_t     s);
      logic [7:0] r;
      case (a)
         OFS_INTERFACE_CONFIG: begin
            r = s.interface_config;
            r[BIT_CHIP_RESET] = 1'b0; // RULE_02
            r[BIT_ALWAYS_ONE] = 1'b1;
         end
         OFS_DEVICE_POWER_CONFIG: r = s.device_power_config;
         OFS_DEVICE_CLASS:        r = {s.device_class_hi, DEVICE_CLASS_CODE}; // RULE_08
         OFS_PART_IDENT_LO:       r = PART_CODE[7:0];   // RULE_09 RULE_18
         OFS_PART_IDENT_HI:       r = PART_CODE[15:8];  // RULE_09 RULE_18
         OFS_SILICON_REVISION:    r = REVISION_CODE;
         OFS_MAKER_IDENT_LO:      r = MAKER_CODE[7:0];  // RULE_18
         OFS_MAKER_IDENT_HI:      r = MAKER_CODE[15:8]; // RULE_18
         OFS_SLEEP_PIN_CONFIG:    r = s.sleep_pin_config;
         OFS_TRANSMIT_SOURCE_SEL: r = s.transmit_source_select;
         OFS_TRANSMIT_ENABLE_BITS: r = s.transmit_enable_bits;
         default:                 r = UNMAPPED_READ;
      endcase
      return r;
   endfunction

   assign rd_data = read_reg(spi_addr, q);

   always_comb begin
      logic [1:0] mode;
      mode            = PMODE_NORMAL;
      next_q          = q;
      next_q.sleep_s1 = i_sleep_pin;
      next_q.sleep_s2 = q.sleep_s1;
      next_q.transmit_enable_bits_s1  = i_txenable_pin;
      next_q.transmit_enable_bits_s2  = q.transmit_enable_bits_s1;
      next_q.chip_reset = 1'b0;
      if (q.reset_cnt != 2'h0) begin
         next_q.reset_cnt  = q.reset_cnt - 2'h1;
         next_q.chip_reset = 1'b1;
      end
      if (spi_wr && q.reset_cnt == 2'h0) begin
         case (spi_wr_addr)
            OFS_INTERFACE_CONFIG: begin
               if (spi_wdata[BIT_CHIP_RESET]) begin
                  next_q.interface_config       = RST_INTERFACE_CONFIG; // RULE_01
                  next_q.device_power_config    = RST_DEVICE_POWER_CONFIG;
                  next_q.device_class_hi        = RST_DEVICE_CLASS_HI;
                  next_q.sleep_pin_config       = RST_SLEEP_PIN_CONFIG;
                  next_q.transmit_source_select = RST_TRANSMIT_SOURCE_SEL;
                  next_q.transmit_enable_bits   = RST_TRANSMIT_ENABLE_BITS;
                  next_q.reset_cnt  = 2'(SOFT_RESET_CYCLES); // RULE_01
                  next_q.chip_reset = 1'b1;
               end else begin
                  // bit 7 never stored, so it self-clears
                  next_q.interface_config = spi_wdata & 8'h7f; // RULE_02
               end
            end
            OFS_DEVICE_POWER_CONFIG:  next_q.device_power_config = spi_wdata;
            OFS_DEVICE_CLASS:         next_q.device_class_hi = spi_wdata[7:4]; // RULE_08
            OFS_SLEEP_PIN_CONFIG:     next_q.sleep_pin_config = spi_wdata;
            OFS_TRANSMIT_SOURCE_SEL:  next_q.transmit_source_select = spi_wdata;
            OFS_TRANSMIT_ENABLE_BITS: next_q.transmit_enable_bits = spi_wdata;
            default: ;
         endcase
      end
      if (q.sleep_s2) begin
         mode = q.sleep_pin_config[BIT_SLEEP_PIN_DEEP] ? PMODE_POWER_DOWN
                                                      : PMODE_SLEEP; // RULE_10 RULE_11
      end else begin
         mode = q.device_power_config[1:0]; // RULE_05
      end
      next_q.power_mode = mode;
      // reduced mode is unsupported and runs as normal
      next_q.asleep     = (mode == PMODE_SLEEP) || (mode == PMODE_POWER_DOWN); // RULE_07
      next_q.power_down = (mode == PMODE_POWER_DOWN); // RULE_05
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q                        <= '0;
         q.interface_config       <= RST_INTERFACE_CONFIG;
         q.device_power_config    <= RST_DEVICE_POWER_CONFIG;
         q.device_class_hi        <= RST_DEVICE_CLASS_HI;
         q.sleep_pin_config       <= RST_SLEEP_PIN_CONFIG;
         q.transmit_source_select <= RST_TRANSMIT_SOURCE_SEL; // RULE_16
         q.transmit_enable_bits   <= RST_TRANSMIT_ENABLE_BITS; // RULE_17
      end else begin
         q <= next_q;
      end
   end

   dacreg_spi_port u_spi (
      .i_ref_clk   (i_ref_clk),
      .i_rst_b     (i_rst_b),
      .i_sclk      (i_spi_sclk),
      .i_cs_b      (i_spi_cs_b),
      .i_sdi       (i_spi_sdi),
      .i_stream_up (q.interface_config[BIT_STREAM_DIRECTION]), // RULE_04
      .i_rd_data   (rd_data),
      .o_addr      (spi_addr),
      .o_wr        (spi_wr),
      .o_wr_addr   (spi_wr_addr),
      .o_wdata     (spi_wdata),
      .o_sdo       (o_spi_sdo),
      .o_sdo_oe_b  (o_spi_sdo_oe_b)
   );

   dacreg_channel u_chan_a (
      .i_ref_clk     (i_ref_clk),
      .i_rst_b       (i_rst_b),
      .i_tx_pin      (q.transmit_enable_bits_s2),
      .i_source_reg  (q.transmit_source_select[BIT_TX_SOURCE_SEL_A]),
      .i_reg_enable  (q.transmit_enable_bits[BIT_TX_REG_ENABLE_A]),
      .i_mute_enable (q.transmit_source_select[BIT_ALARM_MUTE_EN_A]),
      .i_asleep      (q.asleep),
      .i_alarm       (i_alarm),
      .i_mute_mask   (i_mute_mask),
      .i_sample      (i_sample_a),
      .o_sample      (o_converter_a_sample),
      .o_active      (o_converter_a_active),
      .o_muted       (o_converter_a_muted)
   );

   dacreg_channel u_chan_b (
      .i_ref_clk     (i_ref_clk),
      .i_rst_b       (i_rst_b),
      .i_tx_pin      (q.transmit_enable_bits_s2),
      .i_source_reg  (q.transmit_source_select[BIT_TX_SOURCE_SEL_B]),
      .i_reg_enable  (q.transmit_enable_bits[BIT_TX_REG_ENABLE_B]),
      .i_mute_enable (q.transmit_source_select[BIT_ALARM_MUTE_EN_B]),
      .i_asleep      (q.asleep),
      .i_alarm       (i_alarm),
      .i_mute_mask   (i_mute_mask),
      .i_sample      (i_sample_b),
      .o_sample      (o_converter_b_sample),
      .o_active      (o_converter_b_active),
      .o_muted       (o_converter_b_muted)
   );

   // one flop fans out to every sleep domain so they enter together
   assign o_chip_reset        = q.chip_reset;
   assign o_converter_a_sleep = q.asleep; // RULE_07
   assign o_converter_b_sleep = q.asleep;
   assign o_clock_rx_sleep    = q.asleep;
   assign o_reference_sleep   = q.asleep;
   assign o_lvds_rx_sleep     = q.asleep;
   assign o_temp_sensor_sleep = q.asleep;
   assign o_power_down        = q.power_down;
   assign o_power_mode        = q.power_mode;

endmodule

// file: testbench/dacreg_host.sv
// serial register host: 16-bit command then data bytes, msb first
// assumes the bench calls xfer one frame at a time, just after a clock edge
`timescale 1ns/1ns
module dacreg_host (
   input  wire logic i_ref_clk,
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe_b,
   output logic      o_sclk,
   output logic      o_cs_b,
   output logic      o_sdi
);
   initial begin
      o_sclk = 1'b0;
      o_cs_b = 1'b1;
      o_sdi  = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   // ten clocks a phase keeps well above the synchroniser's minimum
   task automatic bit_io(input logic b, inout logic r);
      o_sdi = b;
      tick(10);
      o_sclk = 1'b1;
      r = i_sdo_oe_b ? ~r : i_sdo; // a released line shows no stale value
      tick(10);
      o_sclk = 1'b0;
   endtask
   task automatic xfer(input logic rd, input logic [14:0] a, input int nb,
                       input logic [15:0] wd, output logic [15:0] q);
      logic r;
      r = 1'b0;
      q = 16'h0000;
      o_cs_b = 1'b0;
      tick(10);
      for (int i = 15; i >= 0; i--) bit_io(i == 15 ? rd : a[i], r);
      for (int k = 0; k < nb; k++) begin
         for (int j = 7; j >= 0; j--) begin
            bit_io(wd[8*k+j], r);
            q[8*k+j] = r;
         end
      end
      tick(10);
      o_cs_b = 1'b1;
      tick(8);
   endtask
endmodule

// file: testbench/dacreg_top_asserts.sv
// port-level checks of the register bank outputs
// assumes binding onto dacreg_top, one clock, async active-low reset
`timescale 1ns/1ns
module dacreg_top_asserts
   import dacreg_pkg::*;
(
   input wire logic                i_ref_clk,
   input wire logic                i_rst_b,
   input wire logic [ALARM_W-1:0]  i_alarm,
   input wire logic [ALARM_W-1:0]  i_mute_mask,
   input wire logic [SAMPLE_W-1:0] i_sample_a,
   input wire logic [SAMPLE_W-1:0] o_converter_a_sample,
   input wire logic [SAMPLE_W-1:0] o_converter_b_sample,
   input wire logic                o_converter_a_active,
   input wire logic                o_converter_b_active,
   input wire logic                o_converter_a_muted,
   input wire logic                o_converter_b_muted,
   input wire logic                o_chip_reset,
   input wire logic                o_converter_a_sleep,
   input wire logic                o_clock_rx_sleep,
   input wire logic                o_lvds_rx_sleep,
   input wire logic                o_power_down,
   input wire logic [1:0]          o_power_mode
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   AST_A_PASS: assert property (o_converter_a_active |->
      o_converter_a_sample == $past(i_sample_a)) else $error("a sample lost");
   AST_A_IDLE: assert property (!o_converter_a_active |->
      o_converter_a_sample == IDLE_CODE) else $error("a not idle");
   AST_B_IDLE: assert property (!o_converter_b_active |->
      o_converter_b_sample == IDLE_CODE) else $error("b not idle");
   AST_A_MUTE: assert property (o_converter_a_muted |-> !o_converter_a_active)
      else $error("a muted yet active");
   AST_B_CAUSE: assert property (o_converter_b_muted |->
      $past(|(i_alarm & ~i_mute_mask))) else $error("b muted without alarm");
   AST_SLEEP: assert property (o_converter_a_sleep == o_power_mode[1] &&
      o_clock_rx_sleep == o_power_mode[1] && o_lvds_rx_sleep == o_power_mode[1])
      else $error("sleep versus mode");
   AST_PDOWN: assert property (o_power_down == (o_power_mode == 2'b11))
      else $error("power down versus mode");
   AST_CRST: assert property ($rose(o_chip_reset) |-> o_chip_reset[*2] ##1 !o_chip_reset)
      else $error("chip reset length");
endmodule
bind dacreg_top dacreg_top_asserts i_chk (.*);

// file: testbench/dacreg_top_tb.sv
// self-checking bench of the register bank through its serial pins
// assumes dacreg_host as the serial master and default identity parameters
`timescale 1ns/1ns
module dacreg_top_tb;
   import dacreg_pkg::*;
   logic i_ref_clk, i_rst_b, i_spi_sclk, i_spi_cs_b, i_spi_sdi, o_spi_sdo, o_spi_sdo_oe_b;
   logic i_sleep_pin, i_txenable_pin, o_converter_a_active, o_converter_b_active;
   logic o_converter_a_muted, o_converter_b_muted, o_chip_reset, o_converter_a_sleep;
   logic o_converter_b_sleep, o_clock_rx_sleep, o_reference_sleep, o_lvds_rx_sleep;
   logic o_temp_sensor_sleep, o_power_down;
   logic [1:0]          o_power_mode;
   logic [ALARM_W-1:0]  i_alarm, i_mute_mask;
   logic [SAMPLE_W-1:0] i_sample_a, i_sample_b, o_converter_a_sample, o_converter_b_sample;
   int n_fail = 0;
   int compares = 0;
   dacreg_top i_dut (.*);
   dacreg_host i_host (.i_ref_clk, .i_sdo(o_spi_sdo), .i_sdo_oe_b(o_spi_sdo_oe_b),
      .o_sclk(i_spi_sclk), .o_cs_b(i_spi_cs_b), .o_sdi(i_spi_sdi));
   always #4 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      #1 i_sample_a = i_sample_a + 12'h001;
      i_sample_b = ~i_sample_a;
   end
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task rd(input logic [14:0] a, input int nb, input logic [15:0] e);
      logic [15:0] q;
      i_host.xfer(1'b1, a, nb, 16'h0000, q);
      chk($sformatf("read %h", a), e, q);
   endtask
   task wr(input logic [14:0] a, input int nb, input logic [15:0] d);
      logic [15:0] q;
      i_host.xfer(1'b0, a, nb, d, q);
   endtask
   task chan(input logic ea, input logic eb);
      chk("a active", 16'(ea), 16'(o_converter_a_active));
      chk("b active", 16'(eb), 16'(o_converter_b_active));
   endtask
   task t_reset;
      rd(OFS_INTERFACE_CONFIG, 1, 16'h30);
      rd(OFS_DEVICE_POWER_CONFIG, 1, 16'h0);
      rd(OFS_SLEEP_PIN_CONFIG, 1, 16'h0);
      rd(OFS_TRANSMIT_SOURCE_SEL, 1, 16'h0f);
      rd(OFS_TRANSMIT_ENABLE_BITS, 1, 16'h0);
      chan(1'b0, 1'b0);
   endtask
   task t_ident;
      rd(OFS_DEVICE_CLASS, 1, 16'h09);
      rd(OFS_PART_IDENT_LO, 2, 16'h1234);
      rd(OFS_MAKER_IDENT_LO, 2, 16'h5a5a);
      rd(OFS_SILICON_REVISION, 1, 16'h01);
      wr(OFS_DEVICE_CLASS, 1, 16'hf0);
      wr(OFS_PART_IDENT_LO, 1, 16'h0);
      rd(OFS_DEVICE_CLASS, 1, 16'hf9);
      rd(OFS_PART_IDENT_LO, 1, 16'h34);
      rd(15'h0007, 1, 16'h0);
   endtask
   task t_descend;
      wr(OFS_INTERFACE_CONFIG, 1, 16'h10);
      wr(OFS_TRANSMIT_ENABLE_BITS, 2, 16'h0f03);
      rd(OFS_TRANSMIT_ENABLE_BITS, 2, 16'h0f03);
      chan(1'b1, 1'b1);
      wr(OFS_INTERFACE_CONFIG, 1, 16'h30);
   endtask
   task t_txsrc;
      wr(OFS_TRANSMIT_ENABLE_BITS, 1, 16'h0000);
      i_txenable_pin = 1'b1;
      i_host.tick(6);
      chan(1'b0, 1'b0);
      chk("a idle", 16'(IDLE_CODE), 16'(o_converter_a_sample));
      wr(OFS_TRANSMIT_SOURCE_SEL, 1, 16'h0000);
      chan(1'b1, 1'b1);
      i_txenable_pin = 1'b0;
      i_host.tick(6);
      chan(1'b0, 1'b0);
      i_txenable_pin = 1'b1;
   endtask
   task alm(input logic [7:0] a, input logic [7:0] m);
      i_alarm = a;
      i_mute_mask = m;
      i_host.tick(3);
   endtask
   task t_mute;
      wr(OFS_TRANSMIT_SOURCE_SEL, 1, 16'h4);
      alm(8'h81, 8'h00);
      chk("a muted", 16'h1, 16'(o_converter_a_muted));
      chk("b muted", 16'h0, 16'(o_converter_b_muted));
      chan(1'b0, 1'b1);
      alm(8'h81, 8'h81);
      chan(1'b1, 1'b1);
      wr(OFS_TRANSMIT_SOURCE_SEL, 1, 16'h8);
      alm(8'h80, 8'h01);
      chk("b muted", 16'h1, 16'(o_converter_b_muted));
      chan(1'b1, 1'b0);
      alm(8'h00, 8'h00);
   endtask
   task t_power;
      logic [1:0] m[3] = '{2'h0, 2'h2, 2'h3}; // mode 1 never written
      for (int i = 0; i < 3; i++) begin
         wr(OFS_DEVICE_POWER_CONFIG, 1, {14'h0000, m[i]});
         chk("mode", 16'(m[i]), 16'(o_power_mode));
         chk("asleep", 16'({3{m[i][1]}}),
             16'({o_converter_b_sleep, o_temp_sensor_sleep, o_reference_sleep}));
      end
      wr(OFS_DEVICE_POWER_CONFIG, 1, 16'h0);
      for (int c = 0; c < 2; c++) begin
         wr(OFS_SLEEP_PIN_CONFIG, 1, 16'(c));
         i_sleep_pin = 1'b1;
         i_host.tick(6);
         chk("pin mode", 16'(2 + c), 16'(o_power_mode));
         rd(OFS_DEVICE_POWER_CONFIG, 1, 16'h0);
         i_sleep_pin = 1'b0;
      end
   endtask
   task t_crst;
      wr(OFS_INTERFACE_CONFIG, 1, 16'h80);
      t_reset;
   endtask
   task results;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      {i_ref_clk, i_rst_b, i_sleep_pin, i_txenable_pin} = 4'h0;
      {i_alarm, i_mute_mask, i_sample_a, i_sample_b} = '0;
      repeat (4) @(posedge i_ref_clk);
      #1 i_rst_b = 1'b1;
      i_host.tick(2);
      t_reset;
      t_ident;
      t_descend;
      t_txsrc;
      t_mute;
      t_power;
      t_crst;
      results;
   end
   // one-byte frames take 508 clocks, two-byte frames 668; this leaves ample margin
   initial begin
      #600000;
      n_fail++;
      results;
   end
endmodule
